// [logic/arw_regs.sv]
// Purpose: Flag, enable, result and window registers of a converter, AXI4-Lite slave.
// Assumes: Converter core delivers results on this clock as one-cycle strobes.
// Notes: Settings reach the converter side only after the sync transfer ends.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Writing one to set-register bit 3 enables the sync-ready interrupt.
// - Writing one to set-register bit 2 enables the window interrupt.
// - Writing one to set-register bit 1 enables the overrun interrupt.
// - Writing one to set-register bit 0 enables the result-ready interrupt.
// - Writing one to a flag clears it; zero leaves it.
// - Busy falling sets the sync flag, unless enable or soft reset caused it.
// - Any flag set with its enable on raises the interrupt.
// - Window flag is set the cycle after a matching result.
// - Reading the result clears window and result-ready flags.
// - A new result before the old one is read sets overrun.
// - Result-ready is set as soon as a result is stored.
// - Status bit 7 is high while a settings transfer runs.
// - Result holds 16 bits; single conversions give 12 bits.
// - Left justify without averaging puts the top eight bits in [15:8], rest in [7:4].
// - Right justify without averaging puts the result in [11:0].
// - Averaged results sit in [15:0] shifted by averaging control.
// - The lower bound register feeds the window comparison.
// - The upper bound register feeds the window comparison.
// - Writing one to clear-register bits drops enable and pending request.
module arw_regs
  import arw_pkg::*;
(
  input  wire logic          core_clk_in,
  input  wire logic          nrst_in,
  input  wire logic          ce_in,
  input  wire logic [AW-1:0] s_axi_awaddr_in,
  input  wire logic          s_axi_awvalid_in,
  output logic               s_axi_awready_out,
  input  wire logic [31:0]   s_axi_wdata_in,
  input  wire logic [3:0]    s_axi_wstrb_in,
  input  wire logic          s_axi_wvalid_in,
  output logic               s_axi_wready_out,
  output logic      [1:0]    s_axi_bresp_out,
  output logic               s_axi_bvalid_out,
  input  wire logic          s_axi_bready_in,
  input  wire logic [AW-1:0] s_axi_araddr_in,
  input  wire logic          s_axi_arvalid_in,
  output logic               s_axi_arready_out,
  output logic      [31:0]   s_axi_rdata_out,
  output logic      [1:0]    s_axi_rresp_out,
  output logic               s_axi_rvalid_out,
  input  wire logic          s_axi_rready_in,
  input  wire logic          core_valid_in,
  input  wire logic [15:0]   core_data_in,
  input  wire logic          core_ovs_in,
  output logic               conv_en_out,
  output logic               irq_out
);
  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        arrdy;
    logic        aw_ok;
    logic [5:0]  aw_idx;
    logic        w_ok;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  ctrl;
    logic [2:0]  avg;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [7:0]  c_ctrl;
    logic [2:0]  c_avg;
    logic [15:0] c_lo;
    logic [15:0] c_hi;
    logic [3:0]  ien;
    logic [3:0]  flags;
    logic [15:0] result;
    logic        unread;
    logic        hit;
    logic        irq;
  } arw_st_s;

  arw_st_s     st_r;
  arw_st_s     st_nxt;
  logic        busy;
  logic        load;
  logic        sdone;
  logic [15:0] fres;
  logic        wr_go;
  logic [3:0]  wmask;
  logic        rd_res;
  logic        conv;
  logic        hit_now;
  logic        start;
  logic        quiet;
  logic        swrst;

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx == IDX_CTRL) || (idx == IDX_AVG) || (idx == IDX_IENCLR) ||
             (idx == IDX_IENSET) || (idx == IDX_FLAGS) || (idx == IDX_STATUS) ||
             (idx == IDX_RESULT) || (idx == IDX_WINLO) || (idx == IDX_WINHI);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // Window condition against the converter-side bounds.
  function automatic logic win_match(input logic [2:0]  mode,
                                     input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
    unique case (mode)
      WM_ABOVE:   win_match = v > lo;
      WM_BELOW:   win_match = v < hi;
      WM_INSIDE:  win_match = (v > lo) && (v < hi);
      WM_OUTSIDE: win_match = (v < lo) || (v > hi);
      default:    win_match = 1'b0;
    endcase
  endfunction

  arw_fmt u_fmt (
    .raw_in   (core_data_in),
    .left_in  (st_r.c_ctrl[CTRL_LEFT]),
    .ovs_in   (core_ovs_in),
    .shift_in (st_r.c_avg),
    .res_out  (fres)
  );

  arw_sync u_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .ce_in       (ce_in),
    .start_in    (start),
    .quiet_in    (quiet),
    .busy_out    (busy),
    .load_out    (load),
    .done_out    (sdone)
  );

  always_comb begin
    st_nxt  = st_r;
    wr_go   = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;
    wmask   = (wr_go && st_r.wstrb[0]) ? st_r.wdata[3:0] : 4'h0;
    rd_res  = s_axi_arvalid_in && st_r.arrdy && (s_axi_araddr_in[7:2] == IDX_RESULT);
    conv    = core_valid_in && st_r.c_ctrl[CTRL_EN];
    hit_now = conv && win_match(st_r.c_ctrl[CTRL_WM +: 3], fres,
                                st_r.c_lo, st_r.c_hi);
    start   = 1'b0;
    quiet   = 1'b0;
    swrst   = 1'b0;

    if (s_axi_awvalid_in && st_r.awrdy) begin
      st_nxt.aw_ok  = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr_in[7:2];
    end
    if (s_axi_wvalid_in && st_r.wrdy) begin
      st_nxt.w_ok  = 1'b1;
      st_nxt.wdata = s_axi_wdata_in;
      st_nxt.wstrb = s_axi_wstrb_in;
    end
    if (st_r.bvalid && s_axi_bready_in) begin
      st_nxt.bvalid = 1'b0;
    end

    if (wr_go) begin
      st_nxt.aw_ok  = 1'b0;
      st_nxt.w_ok   = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = mapped(st_r.aw_idx) ? RESP_OKAY : RESP_ERR;
      if (st_r.aw_idx == IDX_CTRL && st_r.wstrb[0]) begin
        st_nxt.ctrl = st_r.wdata[7:0] & ~(8'h01 << CTRL_SWRST);
        swrst = st_r.wdata[CTRL_SWRST];
        start = 1'b1;
        quiet = swrst || (st_r.wdata[CTRL_EN] != st_r.ctrl[CTRL_EN]);
      end
      if (st_r.aw_idx == IDX_AVG && st_r.wstrb[0]) begin
        st_nxt.avg = st_r.wdata[2:0];
        start = 1'b1;
      end
      if (st_r.aw_idx == IDX_WINLO) begin
        st_nxt.lo = merge16(st_r.lo, st_r.wdata, st_r.wstrb);
        start = |st_r.wstrb[1:0];
      end
      if (st_r.aw_idx == IDX_WINHI) begin
        st_nxt.hi = merge16(st_r.hi, st_r.wdata, st_r.wstrb);
        start = |st_r.wstrb[1:0];
      end
      if (st_r.aw_idx == IDX_IENSET) begin
        st_nxt.ien = st_r.ien | wmask;
      end
      if (st_r.aw_idx == IDX_IENCLR) begin
        st_nxt.ien = st_r.ien & ~wmask;
      end
    end

    if (s_axi_arvalid_in && st_r.arrdy) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = mapped(s_axi_araddr_in[7:2]) ? RESP_OKAY : RESP_ERR;
      st_nxt.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr_in[7:2])
        IDX_CTRL:   st_nxt.rdata[7:0]  = st_r.ctrl;
        IDX_AVG:    st_nxt.rdata[2:0]  = st_r.avg;
        IDX_IENCLR: st_nxt.rdata[3:0]  = st_r.ien;
        IDX_IENSET: st_nxt.rdata[3:0]  = st_r.ien;
        IDX_FLAGS:  st_nxt.rdata[3:0]  = st_r.flags;
        IDX_STATUS: st_nxt.rdata[STAT_BUSY] = busy;
        IDX_RESULT: st_nxt.rdata[15:0] = st_r.result;
        IDX_WINLO:  st_nxt.rdata[15:0] = st_r.lo;
        IDX_WINHI:  st_nxt.rdata[15:0] = st_r.hi;
        default:    st_nxt.rdata = 32'h0000_0000;
      endcase
    end else if (st_r.rvalid && s_axi_rready_in) begin
      st_nxt.rvalid = 1'b0;
    end

    if (load) begin
      st_nxt.c_ctrl = st_r.ctrl;
      st_nxt.c_avg  = st_r.avg;
      st_nxt.c_lo   = st_r.lo;
      st_nxt.c_hi   = st_r.hi;
    end

    // A result is captured whole in one edge, so a read never sees a mix.
    if (conv) begin
      st_nxt.result = fres;
      st_nxt.unread = 1'b1;
    end else if (rd_res) begin
      st_nxt.unread = 1'b0;
    end
    st_nxt.hit = hit_now;

    // Set wins over a write-one or result-read clear in the same cycle; a soft reset clears all flags.
    st_nxt.flags = (st_r.flags
                    & ~(((wr_go && st_r.aw_idx == IDX_FLAGS) ? wmask : 4'h0)
                        | (rd_res ? 4'h5 : 4'h0)))
                   | {sdone, st_r.hit, conv && st_r.unread && !rd_res, conv};

    if (swrst) begin
      st_nxt.ien    = 4'h0;
      st_nxt.flags  = FLAG_RST;
      st_nxt.result = WORD_RST;
      st_nxt.unread = 1'b0;
      st_nxt.hit    = 1'b0;
      st_nxt.avg    = 3'h0;
      st_nxt.lo     = WORD_RST;
      st_nxt.hi     = WORD_RST;
      st_nxt.ctrl   = CTRL_RST;
    end

    st_nxt.irq   = |(st_nxt.flags & st_nxt.ien);
    st_nxt.awrdy = !st_nxt.aw_ok && !st_nxt.bvalid;
    st_nxt.wrdy  = !st_nxt.w_ok && !st_nxt.bvalid;
    st_nxt.arrdy = !st_nxt.rvalid;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready_out = st_r.awrdy;
  assign s_axi_wready_out  = st_r.wrdy;
  assign s_axi_bresp_out   = st_r.bresp;
  assign s_axi_bvalid_out  = st_r.bvalid;
  assign s_axi_arready_out = st_r.arrdy;
  assign s_axi_rdata_out   = st_r.rdata;
  assign s_axi_rresp_out   = st_r.rresp;
  assign s_axi_rvalid_out  = st_r.rvalid;
  assign conv_en_out       = st_r.c_ctrl[CTRL_EN];
  assign irq_out           = st_r.irq;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  ien_set_a: assert property (
    ce_in && wr_go && st_r.aw_idx == IDX_IENSET && !swrst
    |=> (st_r.ien & $past(wmask)) == $past(wmask))
    else $error("Enable set write did not set enables.");

  ien_clr_a: assert property (
    ce_in && wr_go && st_r.aw_idx == IDX_IENCLR
    |=> (st_r.ien & $past(wmask)) == 4'h0 && (irq_out == |(st_r.flags & st_r.ien)))
    else $error("Enable clear write left an enable or request.");

  flag_clr_a: assert property (
    ce_in && wr_go && st_r.aw_idx == IDX_FLAGS && wmask[F_SYNC] && !sdone
    |=> !st_r.flags[F_SYNC])
    else $error("Sync flag not cleared by write of one.");

  sync_flag_a: assert property (
    ce_in && sdone && !swrst |=> st_r.flags[F_SYNC])
    else $error("Sync flag not set after busy fell.");

  irq_a: assert property (
    irq_out == |(st_r.flags & st_r.ien))
    else $error("Interrupt does not follow flags and enables.");

  win_flag_a: assert property (
    (ce_in && hit_now && !swrst ##1 ce_in && !swrst) |=> st_r.flags[F_WIN])
    else $error("Window flag not set one cycle after match.");

  rd_clr_a: assert property (
    ce_in && rd_res && !conv && !st_r.hit
    |=> !st_r.flags[F_RDY] && !st_r.flags[F_WIN])
    else $error("Result read did not clear flags.");

  ovr_a: assert property (
    ce_in && conv && st_r.unread && !rd_res && !swrst |=> st_r.flags[F_OVR])
    else $error("Overrun not flagged.");

  rdy_a: assert property (
    ce_in && conv && !swrst |=> st_r.flags[F_RDY] && st_r.result == $past(fres))
    else $error("Result or ready flag missing after conversion.");

  busy_a: assert property (
    ce_in && start |=> busy ##1 1'b1 ##[0:8] load)
    else $error("Busy missing or transfer never ended.");

  left_a: assert property (
    ce_in && conv && st_r.c_ctrl[CTRL_LEFT] && !core_ovs_in && !swrst
    |=> st_r.result == {$past(core_data_in[11:0]), 4'h0})
    else $error("Left justified layout wrong.");

  right_a: assert property (
    ce_in && conv && !st_r.c_ctrl[CTRL_LEFT] && !core_ovs_in && !swrst
    |=> st_r.result == {4'h0, $past(core_data_in[11:0])})
    else $error("Right justified layout wrong.");

  cov_win_c:  cover property (hit_now ##1 1'b1 ##1 st_r.flags[F_WIN]);
  cov_ovr_c:  cover property (conv && st_r.unread && !rd_res);
  cov_sync_c: cover property (sdone ##1 irq_out);
  cov_rd_c:   cover property (rd_res && st_r.flags[F_RDY]);
endmodule
`default_nettype wire

// [logic/arw_pkg.sv]
// Purpose: Shared constants of the converter result, flag and window register block.
// Assumes: One 50 MHz clock; registers reached over AXI4-Lite.
// Notes: Byte address of a register is four times its index.
`default_nettype none
package arw_pkg;
  localparam int unsigned CLK_NS   = 20;
  localparam int unsigned SYNC_NS  = 60;
  localparam int unsigned SYNC_CYC = (SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0]  SYNC_LAST = 2'(SYNC_CYC - 1);

  localparam int unsigned AW = 8;

  localparam logic [5:0] IDX_CTRL   = 6'h00;
  localparam logic [5:0] IDX_AVG    = 6'h02;
  localparam logic [5:0] IDX_IENCLR = 6'h16;
  localparam logic [5:0] IDX_IENSET = 6'h17;
  localparam logic [5:0] IDX_FLAGS  = 6'h18;
  localparam logic [5:0] IDX_STATUS = 6'h19;
  localparam logic [5:0] IDX_RESULT = 6'h1a;
  localparam logic [5:0] IDX_WINLO  = 6'h1c;
  localparam logic [5:0] IDX_WINHI  = 6'h20;

  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_SWRST = 1;
  localparam int unsigned CTRL_LEFT  = 2;
  localparam int unsigned CTRL_WM    = 3;
  localparam int unsigned STAT_BUSY  = 7;

  localparam int unsigned F_RDY  = 0;
  localparam int unsigned F_OVR  = 1;
  localparam int unsigned F_WIN  = 2;
  localparam int unsigned F_SYNC = 3;

  localparam logic [2:0] WM_OFF     = 3'h0;
  localparam logic [2:0] WM_ABOVE   = 3'h1;
  localparam logic [2:0] WM_BELOW   = 3'h2;
  localparam logic [2:0] WM_INSIDE  = 3'h3;
  localparam logic [2:0] WM_OUTSIDE = 3'h4;

  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [3:0]  FLAG_RST  = 4'h0;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
endpackage
`default_nettype wire

// [logic/arw_fmt.sv]
// Purpose: Places a raw conversion value into the 16-bit result layout.
// Assumes: Raw single conversions carry 12 bits in [11:0].
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module arw_fmt
  import arw_pkg::*;
(
  input  wire logic [15:0] raw_in,
  input  wire logic        left_in,
  input  wire logic        ovs_in,
  input  wire logic [2:0]  shift_in,
  output logic      [15:0] res_out
);
  always_comb begin
    if (ovs_in) begin
      res_out = raw_in >> shift_in;
    end else if (left_in) begin
      res_out = {raw_in[11:0], 4'h0};
    end else begin
      res_out = {4'h0, raw_in[11:0]};
    end
  end
endmodule
`default_nettype wire

// [logic/arw_sync.sv]
// Purpose: Times the transfer of written settings into the converter side.
// Assumes: A restart during a transfer lengthens it.
// Notes: Busy falls with a one-cycle load pulse; done also unless quiet.
`timescale 1ns/1ps
`default_nettype none
module arw_sync
  import arw_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  input  wire logic start_in,
  input  wire logic quiet_in,
  output logic      busy_out,
  output logic      load_out,
  output logic      done_out
);
  typedef struct packed {
    logic [1:0] cnt;
    logic       busy;
    logic       quiet;
    logic       load;
    logic       done;
  } arw_sy_s;

  arw_sy_s st_r;
  arw_sy_s st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.load = 1'b0;
    st_nxt.done = 1'b0;
    if (start_in) begin
      st_nxt.busy  = 1'b1;
      st_nxt.cnt   = SYNC_LAST;
      st_nxt.quiet = (st_r.busy & st_r.quiet) | quiet_in;
    end else if (st_r.busy) begin
      if (st_r.cnt == 2'h0) begin
        st_nxt.busy = 1'b0;
        st_nxt.load = 1'b1;
        st_nxt.done = ~st_r.quiet;
      end else begin
        st_nxt.cnt = st_r.cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  assign busy_out = st_r.busy;
  assign load_out = st_r.load;
  assign done_out = st_r.done;
endmodule
`default_nettype wire

// [testbench/tb_adc_result_irq_window_regs.sv]
// Purpose: Self-checking bench for the converter flag, enable, result and window registers.
// Assumes: Registers are reached over AXI4-Lite at byte address four times the index.
// Notes: The converter strobe is driven directly; settings writes wait out the sync transfer.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_result_irq_window_regs
  import arw_pkg::*;
();
  logic          core_clk;
  logic          nrst;
  logic          ce;
  logic [AW-1:0] awaddr;
  logic [AW-1:0] araddr;
  logic          awvalid;
  logic          wvalid;
  logic          bready;
  logic          arvalid;
  logic          rready;
  logic [31:0]   wdata;
  logic [3:0]    wstrb;
  logic          core_valid;
  logic [15:0]   core_data;
  logic          core_ovs;
  logic          awready;
  logic          wready;
  logic          bvalid;
  logic          arready;
  logic          rvalid;
  logic [1:0]    bresp;
  logic [1:0]    rresp;
  logic [31:0]   rdata;
  logic          conv_en;
  logic          irq;
  int            bad_count;
  int            cmp_count;
  logic [1:0]    rs;
  logic [31:0]   got;
  logic [31:0]   acc;
  logic [15:0]   win_val [4] = '{16'h0150, 16'h0050, 16'h0100, 16'h01ff};
  logic [7:0]    win_exp [4] = '{8'h05, 8'h01, 8'h01, 8'h05};
  logic [5:0]    rst_idx [7] = '{IDX_FLAGS, IDX_STATUS, IDX_RESULT, IDX_WINLO, IDX_WINHI,
                                 IDX_IENSET, IDX_IENCLR};

  arw_regs dut (
    .core_clk_in       (core_clk),
    .nrst_in           (nrst),
    .ce_in             (ce),
    .s_axi_awaddr_in   (awaddr),
    .s_axi_awvalid_in  (awvalid),
    .s_axi_awready_out (awready),
    .s_axi_wdata_in    (wdata),
    .s_axi_wstrb_in    (wstrb),
    .s_axi_wvalid_in   (wvalid),
    .s_axi_wready_out  (wready),
    .s_axi_bresp_out   (bresp),
    .s_axi_bvalid_out  (bvalid),
    .s_axi_bready_in   (bready),
    .s_axi_araddr_in   (araddr),
    .s_axi_arvalid_in  (arvalid),
    .s_axi_arready_out (arready),
    .s_axi_rdata_out   (rdata),
    .s_axi_rresp_out   (rresp),
    .s_axi_rvalid_out  (rvalid),
    .s_axi_rready_in   (rready),
    .core_valid_in     (core_valid),
    .core_data_in      (core_data),
    .core_ovs_in       (core_ovs),
    .conv_en_out       (conv_en),
    .irq_out           (irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk(name, exp, d);
    chk({name, " resp"}, {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // Settings writes start a sync transfer, so the bench lets it finish.
  task automatic wcfg(input logic [5:0] idx, input logic [31:0] d);
    logic [1:0] r;
    wr(idx, d, r);
    chk("cfg resp", {30'h0, RESP_OKAY}, {30'h0, r});
    repeat (8) @(posedge core_clk);
  endtask

  task automatic conv(input logic [15:0] d, input logic ovs);
    @(posedge core_clk);
    core_valid <= 1'b1;
    core_data <= d;
    core_ovs <= ovs;
    @(posedge core_clk);
    core_valid <= 1'b0;
    core_ovs <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, core_valid, core_ovs} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    core_data = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    foreach (rst_idx[i]) rchk("reset value", rst_idx[i], 32'h0);
    rd(6'h3f, got, rs);
    chk("unmapped read resp", {30'h0, RESP_ERR}, {30'h0, rs});
    chk("unmapped read data", 32'h0, got);
    wr(6'h3f, 32'h0000_00ff, rs);
    chk("unmapped write resp", {30'h0, RESP_ERR}, {30'h0, rs});
    wr(IDX_RESULT, 32'h0000_ffff, rs);
    rchk("result read only", IDX_RESULT, 32'h0);
    acc = 32'h0;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_IENSET, 32'h1 << i, rs);
      acc = acc | (32'h1 << i);
      rchk("enable set", IDX_IENSET, acc);
    end
    wr(IDX_IENSET, 32'h0, rs);
    rchk("enable set zero", IDX_IENSET, 32'h0f);
    wr(IDX_IENCLR, 32'h0f, rs);
    rchk("enable clear", IDX_IENCLR, 32'h0);
    wcfg(IDX_CTRL, 32'h1 << CTRL_EN);
    chk("converter enable", 32'h1, {31'h0, conv_en});
    rchk("no sync flag on enable", IDX_FLAGS, 32'h0);
    wr(IDX_IENSET, 32'h08, rs);
    wcfg(IDX_WINLO, 32'h0100);
    rchk("sync flag", IDX_FLAGS, 32'h08);
    chk("irq on sync", 32'h1, {31'h0, irq});
    wr(IDX_FLAGS, 32'h0, rs);
    rchk("flag write zero", IDX_FLAGS, 32'h08);
    wr(IDX_FLAGS, 32'h08, rs);
    rchk("flag write one", IDX_FLAGS, 32'h0);
    chk("irq after clear", 32'h0, {31'h0, irq});
    wr(IDX_IENCLR, 32'h08, rs);
    // The status read is taken while the transfer of this write still runs.
    wr(IDX_WINHI, 32'h0200, rs);
    chk("cfg resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    rchk("status busy", IDX_STATUS, 32'h80);
    repeat (8) @(posedge core_clk);
    rchk("lower bound", IDX_WINLO, 32'h0100);
    rchk("upper bound", IDX_WINHI, 32'h0200);
    rchk("status idle", IDX_STATUS, 32'h0);
    wr(IDX_FLAGS, 32'h0f, rs);
    conv(16'h0abc, 1'b0);
    rchk("ready flag", IDX_FLAGS, 32'h01);
    rchk("right result", IDX_RESULT, 32'h0abc);
    rchk("flags after read", IDX_FLAGS, 32'h0);
    conv(16'h0111, 1'b0);
    conv(16'h0222, 1'b0);
    rchk("overrun flag", IDX_FLAGS, 32'h03);
    rchk("latest result", IDX_RESULT, 32'h0222);
    rchk("overrun kept", IDX_FLAGS, 32'h02);
    wr(IDX_FLAGS, 32'h02, rs);
    rchk("overrun cleared", IDX_FLAGS, 32'h0);
    wcfg(IDX_CTRL, (32'h1 << CTRL_EN) | (32'h1 << CTRL_LEFT));
    wr(IDX_FLAGS, 32'h0f, rs);
    conv(16'h0abc, 1'b0);
    rchk("left result", IDX_RESULT, 32'habc0);
    wcfg(IDX_CTRL, 32'h1 << CTRL_EN);
    wcfg(IDX_AVG, 32'h2);
    wr(IDX_FLAGS, 32'h0f, rs);
    conv(16'h1234, 1'b1);
    rchk("averaged result", IDX_RESULT, 32'h048d);
    wcfg(IDX_CTRL, (32'h1 << CTRL_EN) | (32'(WM_INSIDE) << CTRL_WM));
    wr(IDX_IENSET, 32'h04, rs);
    foreach (win_val[i]) begin
      wr(IDX_FLAGS, 32'h0f, rs);
      conv(win_val[i], 1'b0);
      rchk("window flags", IDX_FLAGS, {24'h0, win_exp[i]});
      chk("window irq", {31'h0, win_exp[i][2]}, {31'h0, irq});
      rd(IDX_RESULT, got, rs);
    end
    rchk("window read clear", IDX_FLAGS, 32'h0);
    // A strobe while the clock enable is low must leave every register as it was.
    @(posedge core_clk);
    ce <= 1'b0;
    conv(16'h0150, 1'b0);
    ce <= 1'b1;
    rchk("frozen flags", IDX_FLAGS, 32'h0);
    rchk("frozen result", IDX_RESULT, 32'h01ff);
    conv(16'h0150, 1'b0);
    chk("irq window set", 32'h1, {31'h0, irq});
    wr(IDX_IENCLR, 32'h04, rs);
    repeat (2) @(posedge core_clk);
    chk("irq after enable clear", 32'h0, {31'h0, irq});
    // Soft reset clears flags and enables without raising the sync flag.
    wr(IDX_IENSET, 32'h0f, rs);
    chk("irq before soft reset", 32'h1, {31'h0, irq});
    wcfg(IDX_CTRL, 32'h1 << CTRL_SWRST);
    rchk("no sync flag on soft reset", IDX_FLAGS, 32'h0);
    rchk("enables after soft reset", IDX_IENSET, 32'h0);
    rchk("bound after soft reset", IDX_WINLO, 32'h0);
    chk("irq after soft reset", 32'h0, {31'h0, irq});
    chk("converter off", 32'h0, {31'h0, conv_en});
    conclude();
  end
endmodule
`default_nettype wire
